// ---- design/fpps_pkg.sv ----
// Behaviour
// - data registers hold extended values only; outside operands are widened first
// - reset or null restore loads every data register with positive quiet nan
// - control register bits 31 to 16 read zero and ignore writes
// - reset or null restore clears the control register to all zeros
// - each trap-enable bit gates the trap of one exception class
// - rounding mode: 00 nearest, 01 toward zero, 10 minus inf, 11 plus inf
// - precision: 00 extended, 01 single, 10 double, 11 undefined
// - single rounds mantissa at 24 bits, double at 64 bits
// - status register fully read/write; reset or null restore clears it
// - conditions are only trusted when produced by a float instruction
// - arithmetic and move-in update negative, zero, infinity, nan flags; other moves leave them
// - quotient byte keeps sign and seven low bits until the next quotient result or a status write replaces it
// - exception byte cleared at start of exception-capable operations only
// - most operations, not moves, or an exception summary into the accrued byte
// - accrued terms: invalid, overflow, underflow, divide, inexact combinations
// - accrued byte cleared only by status write, reset or null restore
// - writing accrued bits never raises nor suppresses an exception
// - trap-capable instructions load their address into the address register first
// - control moves that do not write the address register, and multiple moves, leave the address register unchanged
// - reset or null restore clears the address register
package fpps_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int EXT_W = 80;
  localparam int NUM_DREGS = 8;
  localparam logic [EXT_W-1:0] QNAN_POS = 80'h7fff_ffff_ffff_ffff_ffff;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] IADDR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // control layout: [15:8] trap enables, [7:6] precision, [5:4] mode
  // ----------------------------------------------------------------
  // field layout fixed here
  localparam int CTRL_EN_LSB = 8;
  localparam int CTRL_ROUNDING_PRECISION_FIELD_LSB = 6;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [7:0] CTRL_MODE_MASK = 8'hf0;

  // exception and enable byte bit positions
  localparam int EXC_BSUN = 7;
  localparam int EXC_SIGNALING_NAN_FLAG = 6;
  localparam int EXC_OPERAND_ERROR_FLAG = 5;
  localparam int EXC_OVERFLOW_FLAG = 4;
  localparam int EXC_UNDERFLOW_FLAG = 3;
  localparam int EXC_DZ = 2;
  localparam int EXC_SECOND_INEXACT_FLAG = 1;
  localparam int EXC_FIRST_INEXACT_FLAG = 0;
  // accrued byte bit positions, bits 2:0 unused
  localparam int ACCRUED_EXCEPTION_BYTE_IOP = 7;
  localparam int ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG = 6;
  localparam int ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG = 5;
  localparam int ACCRUED_EXCEPTION_BYTE_DZ = 4;
  localparam int ACCRUED_EXCEPTION_BYTE_ACCRUED_INEXACT = 3;
  // condition byte bit positions
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_I = 1;
  localparam int CC_NAN = 0;

  // mantissa rounding boundaries
  localparam logic [6:0] RB_EXT = 7'h40;
  localparam logic [6:0] RB_SGL = 7'h18;
  localparam logic [6:0] RB_DBL = 7'h40;

  // exponent rebiasing into extended format
  localparam logic [14:0] EXP_MAX = 15'h7fff;
  localparam logic [14:0] SGL_REBIAS = 15'h3f80;
  localparam logic [14:0] SGL_DENORM_EXP = 15'h3f81;
  localparam logic [14:0] DBL_REBIAS = 15'h3c00;
  localparam logic [14:0] DBL_DENORM_EXP = 15'h3c01;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    round_nearest = 2'b00,
    round_toward_zero = 2'b01,
    round_toward_minus_inf = 2'b10,
    round_toward_plus_inf = 2'b11
  } fpps_rmode_t;

  typedef enum logic [1:0] {
    rounding_precision_field_extended = 2'b00,
    rounding_precision_field_single = 2'b01,
    rounding_precision_field_double = 2'b10,
    rounding_precision_field_undefined = 2'b11
  } fpps_rounding_precision_field_t;

  typedef enum logic [1:0] {
    sel_control = 2'b00,
    sel_status = 2'b01,
    sel_iaddr = 2'b10,
    sel_none = 2'b11
  } fpps_csel_t;

  typedef enum logic [1:0] {
    op_arith = 2'b00,
    op_move_in = 2'b01,
    op_move_out = 2'b10,
    op_move_multiple = 2'b11
  } fpps_op_t;

  typedef enum logic [1:0] {
    fmt_extended = 2'b00,
    fmt_single = 2'b01,
    fmt_double = 2'b10,
    fmt_reserved = 2'b11
  } fpps_fmt_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cc;
    logic [7:0] quot;
    logic [7:0] exception_status_byte;
    logic [7:0] accrued_exception_byte;
  } fpps_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    fpps_csel_t sel;
    logic [31:0] wdata;
  } fpps_creg_req_t;

  typedef struct packed {
    logic start;
    fpps_op_t kind;
    logic [31:0] addr;
  } fpps_op_start_t;

  typedef struct packed {
    logic done;
    fpps_op_t kind;
    logic wr_dest;
    logic [2:0] dest;
    fpps_fmt_t fmt;
    logic [EXT_W-1:0] value;
    logic [7:0] exception_status_byte;
    logic quot_valid;
    logic [7:0] quot;
  } fpps_op_done_t;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic logic trap_capable(input fpps_op_t k);
    trap_capable = (k != op_move_multiple);
  endfunction

  function automatic logic [7:0] cond_flags(input logic [EXT_W-1:0] v);
    logic [14:0] e;
    logic [62:0] f;
    e = v[78:64];
    f = v[62:0];
    cond_flags = 8'h00;
    cond_flags[CC_N] = v[79];
    cond_flags[CC_Z] = (e == 15'h0000) && (v[63:0] == 64'h0);
    cond_flags[CC_I] = (e == EXP_MAX) && (f == 63'h0);
    cond_flags[CC_NAN] = (e == EXP_MAX) && (f != 63'h0);
  endfunction

endpackage

// ---- design/fpps_accrue.sv ----
`timescale 1ns/10ps
module fpps_accrue
  import fpps_pkg::*;
(
  input wire logic [7:0] old_accrued_exception_byte,
  input wire logic [7:0] exception_status_byte,
  output logic [7:0] new_accrued_exception_byte
);
  import fpps_pkg::*;

  always_comb
  begin
    new_accrued_exception_byte = old_accrued_exception_byte;
    new_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_IOP] = old_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_IOP] | exception_status_byte[EXC_SIGNALING_NAN_FLAG] | exception_status_byte[EXC_OPERAND_ERROR_FLAG];
    new_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG] = old_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_OVERFLOW_FLAG] | exception_status_byte[EXC_OVERFLOW_FLAG];
    new_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG] = old_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_UNDERFLOW_FLAG] | (exception_status_byte[EXC_UNDERFLOW_FLAG] & exception_status_byte[EXC_SECOND_INEXACT_FLAG]);
    new_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_DZ] = old_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_DZ] | exception_status_byte[EXC_DZ];
    new_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_ACCRUED_INEXACT] = old_accrued_exception_byte[ACCRUED_EXCEPTION_BYTE_ACCRUED_INEXACT] | exception_status_byte[EXC_FIRST_INEXACT_FLAG] | exception_status_byte[EXC_SECOND_INEXACT_FLAG] | exception_status_byte[EXC_OVERFLOW_FLAG];
  end

endmodule

// ---- design/fpps_state.sv ----
`timescale 1ns/10ps
module fpps_state
  import fpps_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic null_restore,
  input fpps_pkg::fpps_creg_req_t creg_req,
  input fpps_pkg::fpps_op_start_t op_start,
  input fpps_pkg::fpps_op_done_t op_done,
  input wire logic dreg_rd,
  input wire logic [2:0] dreg_rd_idx,
  output logic [31:0] creg_rdata,
  output logic creg_rvalid,
  output logic [79:0] dreg_rdata,
  output logic dreg_rvalid,
  output logic [7:0] trap_enable,
  output fpps_pkg::fpps_rmode_t round_mode,
  output fpps_pkg::fpps_rounding_precision_field_t round_rounding_precision_field,
  output logic [6:0] mant_round_bits,
  output logic [7:0] cond_flags_out
);
  import fpps_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [EXT_W-1:0] dregs [NUM_DREGS];
  logic [EXT_W-1:0] next_dregs [NUM_DREGS];
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  fpps_status_t status;
  fpps_status_t next_status;
  logic [31:0] iaddr;
  logic [31:0] next_iaddr;
  logic [6:0] next_round_bits;
  logic [31:0] next_creg_rdata;
  logic next_creg_rvalid;
  logic [79:0] next_dreg_rdata;
  logic next_dreg_rvalid;
  logic [7:0] accrued;
  logic [EXT_W-1:0] widened;

  // ----------------------------------------------------------------
  // operand widening
  // ----------------------------------------------------------------
  function automatic logic [EXT_W-1:0] to_extended(input fpps_fmt_t fmt, input logic [EXT_W-1:0] raw);
    logic [7:0] se;
    logic [10:0] de;
    to_extended = raw;
    se = raw[30:23];
    de = raw[62:52];
    case (fmt)
      fmt_single:
      begin
        if (se == 8'h00 && raw[22:0] == 23'h0)
          to_extended = {raw[31], 15'h0000, 64'h0};
        else if (se == 8'hff)
          to_extended = {raw[31], EXP_MAX, 1'b0, raw[22:0], 40'h0};
        else if (se == 8'h00)
          to_extended = {raw[31], SGL_DENORM_EXP, 1'b0, raw[22:0], 40'h0};
        else
          to_extended = {raw[31], 15'({7'h00, se} + SGL_REBIAS), 1'b1, raw[22:0], 40'h0};
      end
      fmt_double:
      begin
        if (de == 11'h000 && raw[51:0] == 52'h0)
          to_extended = {raw[63], 15'h0000, 64'h0};
        else if (de == 11'h7ff)
          to_extended = {raw[63], EXP_MAX, 1'b0, raw[51:0], 11'h000};
        else if (de == 11'h000)
          to_extended = {raw[63], DBL_DENORM_EXP, 1'b0, raw[51:0], 11'h000};
        else
          to_extended = {raw[63], 15'({4'h0, de} + DBL_REBIAS), 1'b1, raw[51:0], 11'h000};
      end
      default:
        to_extended = raw;
    endcase
  endfunction

  assign widened = to_extended(op_done.fmt, op_done.value);

  // the accrual sees the exception byte of the finishing operation
  fpps_accrue u_accrue (
    .old_accrued_exception_byte(status.accrued_exception_byte),
    .exception_status_byte(op_done.exception_status_byte),
    .new_accrued_exception_byte(accrued)
  );

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_DREGS; i++)
      next_dregs[i] = dregs[i];
    if (null_restore)
    begin
      for (int i = 0; i < NUM_DREGS; i++)
        next_dregs[i] = QNAN_POS;
    end
    else if (op_done.done && op_done.wr_dest && op_done.kind != op_move_out)
      next_dregs[op_done.dest] = widened;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_DREGS; i++)
        dregs[i] <= QNAN_POS;
    end
    else
    begin
      for (int i = 0; i < NUM_DREGS; i++)
        dregs[i] <= next_dregs[i];
    end
  end

  // ----------------------------------------------------------------
  // control, status and address registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_status = status;
    next_iaddr = iaddr;
    // software moves first; hardware events below win in the same cycle, except accrued bits, where a status write's byte is ORed in
    if (creg_req.wr)
    begin
      case (creg_req.sel)
        sel_control: next_ctrl = {creg_req.wdata[15:8], creg_req.wdata[7:0] & CTRL_MODE_MASK};
        // direct writes may leave conditions untrusted
        sel_status: next_status = creg_req.wdata;
        sel_iaddr: next_iaddr = creg_req.wdata;
        default: next_ctrl = ctrl;
      endcase
    end
    if (op_start.start && trap_capable(op_start.kind))
    begin
      next_iaddr = op_start.addr;
      next_status.exception_status_byte = 8'h00;
    end
    if (op_done.done && trap_capable(op_done.kind))
    begin
      next_status.exception_status_byte = op_done.exception_status_byte;
      // quotient replaced only by a quotient result
      if (op_done.quot_valid)
        next_status.quot = op_done.quot;
      if (op_done.kind != op_move_out)
        next_status.cc = cond_flags(widened);
      if (op_done.kind == op_arith)
        next_status.accrued_exception_byte = creg_req.wr && creg_req.sel == sel_status ? (accrued | creg_req.wdata[7:0]) : accrued;
    end
    if (null_restore)
    begin
      next_ctrl = CTRL_RESET;
      next_status = STAT_RESET;
      next_iaddr = IADDR_RESET;
    end
  end

  always_comb
  begin
    case (fpps_rounding_precision_field_t'(next_ctrl[CTRL_ROUNDING_PRECISION_FIELD_LSB +: 2]))
      rounding_precision_field_single: next_round_bits = RB_SGL;
      rounding_precision_field_double: next_round_bits = RB_DBL;
      default: next_round_bits = RB_EXT;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= CTRL_RESET;
      status <= STAT_RESET;
      iaddr <= IADDR_RESET;
      mant_round_bits <= RB_EXT;
    end
    else
    begin
      ctrl <= next_ctrl;
      status <= next_status;
      iaddr <= next_iaddr;
      mant_round_bits <= next_round_bits;
    end
  end

  // enables straight from the control byte
  // accrued bits never reach the trap enables
  assign trap_enable = ctrl[CTRL_EN_LSB +: 8];
  assign round_mode = fpps_rmode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign round_rounding_precision_field = fpps_rounding_precision_field_t'(ctrl[CTRL_ROUNDING_PRECISION_FIELD_LSB +: 2]);
  assign cond_flags_out = status.cc;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    next_creg_rdata = creg_rdata;
    next_creg_rvalid = creg_req.rd;
    next_dreg_rdata = dreg_rdata;
    next_dreg_rvalid = dreg_rd;
    // reads return pre-update contents; they never disturb the address register
    // register reads leave address intact
    if (creg_req.rd)
    begin
      case (creg_req.sel)
        sel_control: next_creg_rdata = {16'h0000, ctrl};
        sel_status: next_creg_rdata = status;
        sel_iaddr: next_creg_rdata = iaddr;
        default: next_creg_rdata = 32'h0000_0000;
      endcase
    end
    if (dreg_rd)
      next_dreg_rdata = dregs[dreg_rd_idx];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      creg_rdata <= 32'h0000_0000;
      creg_rvalid <= 1'b0;
      dreg_rdata <= QNAN_POS;
      dreg_rvalid <= 1'b0;
    end
    else
    begin
      creg_rdata <= next_creg_rdata;
      creg_rvalid <= next_creg_rvalid;
      dreg_rdata <= next_dreg_rdata;
      dreg_rvalid <= next_dreg_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic all_nan;
  always_comb
  begin
    all_nan = 1'b1;
    for (int i = 0; i < NUM_DREGS; i++)
      all_nan = all_nan & (dregs[i] == QNAN_POS);
  end

  sequence s_trap_start;
    op_start.start && trap_capable(op_start.kind) && !null_restore && !creg_req.wr;
  endsequence

  sequence s_no_addr_source;
    !(op_start.start && trap_capable(op_start.kind)) && !null_restore && !(creg_req.wr && creg_req.sel == sel_iaddr);
  endsequence

  a_restore_nan_regs: assert property (null_restore |=> all_nan)
    else $error("data registers not nan after null restore");
  a_ctrl_read_upper: assert property (creg_req.rd && creg_req.sel == sel_control |=> creg_rdata[31:16] == 16'h0000)
    else $error("control upper half read nonzero");
  a_restore_clears_all: assert property (null_restore |=> ctrl == 16'h0000 && status == 32'h0 && iaddr == 32'h0)
    else $error("null restore left state");
  a_mode_write: assert property (creg_req.wr && creg_req.sel == sel_control && !null_restore
      |=> round_mode == $past(creg_req.wdata[5:4]) && trap_enable == $past(creg_req.wdata[15:8]))
    else $error("control write not reflected");
  a_single_bound: assert property (round_rounding_precision_field == rounding_precision_field_single |-> mant_round_bits == 7'd24)
    else $error("single precision boundary wrong");
  a_cc_unchanged: assert property (op_done.done && op_done.kind inside {op_move_out, op_move_multiple}
      && !null_restore && !creg_req.wr |=> $stable(status.cc))
    else $error("condition flags changed by a move");
  a_quot_hold: assert property (!(op_done.done && op_done.quot_valid) && !null_restore && !creg_req.wr
      |=> $stable(status.quot))
    else $error("quotient changed without cause");
  a_exc_start_clear: assert property (s_trap_start ##0 !op_done.done |=> status.exception_status_byte == 8'h00)
    else $error("exception byte not cleared at start");
  a_accrued_sticky: assert property (!null_restore && !(creg_req.wr && creg_req.sel == sel_status)
      |=> (status.accrued_exception_byte & $past(status.accrued_exception_byte)) == $past(status.accrued_exception_byte))
    else $error("accrued bit cleared by hardware");
  a_iaddr_capture: assert property (s_trap_start |=> iaddr == $past(op_start.addr))
    else $error("address not captured");
  a_iaddr_hold: assert property (s_no_addr_source |=> $stable(iaddr))
    else $error("address register changed by a move");
  a_status_write: assert property (creg_req.wr && creg_req.sel == sel_status && !op_start.start && !op_done.done
      && !null_restore |=> status == $past(creg_req.wdata))
    else $error("status write not taken whole");

endmodule

// ---- test/fpps_iu_model.sv ----
`timescale 1ns/10ps
module fpps_iu_model
  import fpps_pkg::*;
(
  input wire logic clk,
  output fpps_pkg::fpps_op_start_t op_start,
  output fpps_pkg::fpps_op_done_t op_done
);
  import fpps_pkg::*;

  initial
  begin
    op_start = '0;
    op_done = '0;
  end

  // ---------------------------------------------------------------
  // instruction issue
  // ---------------------------------------------------------------
  // conditions consulted only after an instruction finishes
  task automatic run_op(input fpps_op_t kind, input logic [31:0] addr, input logic [2:0] dest,
      input fpps_fmt_t fmt, input logic [79:0] value, input logic [7:0] exception_status_byte, input logic qv,
      input logic [7:0] q);
    fpps_op_start_t s;
    fpps_op_done_t d;
    s = '{start: 1'b1, kind: kind, addr: addr};
    d = '{done: 1'b1, kind: kind, wr_dest: 1'b1, dest: dest, fmt: fmt, value: value, exception_status_byte: exception_status_byte,
      quot_valid: qv, quot: q};
    @(negedge clk);
    op_start <= s;
    @(negedge clk);
    s = ~s;
    s.start = 1'b0;
    op_start <= s;
    op_done <= d;
    @(negedge clk);
    // released fields show garbage so stale values are never trusted
    d = ~d;
    d.done = 1'b0;
    op_done <= d;
  endtask
endmodule

// ---- test/float_unit_program_state_tb_top.sv ----
`timescale 1ns/10ps
module float_unit_program_state_tb_top
  import fpps_pkg::*;
;
  import fpps_pkg::*;

  logic clk = 1'b0;
  logic rstn;
  logic null_restore;
  logic dreg_rd;
  logic [2:0] dreg_rd_idx;
  fpps_creg_req_t creg_req;
  fpps_op_start_t op_start;
  fpps_op_done_t op_done;
  logic [31:0] creg_rdata;
  logic creg_rvalid;
  logic [79:0] dreg_rdata;
  logic dreg_rvalid;
  logic [7:0] trap_enable;
  fpps_rmode_t round_mode;
  fpps_rounding_precision_field_t round_rounding_precision_field;
  logic [6:0] mant_round_bits;
  logic [7:0] cond_flags_out;
  int failures = 0;
  int n_tests = 0;
  logic [15:0] seed;
  logic [31:0] e_ctrl, e_stat, e_iaddr;
  logic [79:0] e_dreg [8];

  always #25 clk = ~clk;

  fpps_state uut (.clk(clk), .rstn(rstn), .null_restore(null_restore), .creg_req(creg_req),
    .op_start(op_start), .op_done(op_done), .dreg_rd(dreg_rd), .dreg_rd_idx(dreg_rd_idx),
    .creg_rdata(creg_rdata), .creg_rvalid(creg_rvalid), .dreg_rdata(dreg_rdata),
    .dreg_rvalid(dreg_rvalid), .trap_enable(trap_enable), .round_mode(round_mode),
    .round_rounding_precision_field(round_rounding_precision_field), .mant_round_bits(mant_round_bits), .cond_flags_out(cond_flags_out));
  fpps_iu_model u_iu (.clk(clk), .op_start(op_start), .op_done(op_done));

  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd32();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd32[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd32[31:16] = seed;
  endfunction

  function automatic logic [7:0] exp_cc(input logic [79:0] v);
    exp_cc = {4'h0, v[79], v[78:0] == 79'h0, v[78:64] == 15'h7fff && v[62:0] == 63'h0,
      v[78:64] == 15'h7fff && v[62:0] != 63'h0};
  endfunction

  function automatic logic [7:0] exp_accr(input logic [7:0] a, input logic [7:0] x);
    exp_accr = a | {x[6] | x[5], x[4], x[3] & x[1], x[2], x[0] | x[1] | x[4], 3'h0};
  endfunction

  // normal single operands only: rebias exponent, make the integer bit explicit
  function automatic logic [79:0] widen_single(input logic [31:0] s);
    widen_single = {s[31], 15'(s[30:23]) + SGL_REBIAS, 1'b1, s[22:0], 40'h0};
  endfunction

  // normal double operands only
  function automatic logic [79:0] widen_double(input logic [63:0] s);
    widen_double = {s[63], 15'(s[62:52]) + DBL_REBIAS, 1'b1, s[51:0], 11'h000};
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // register moves
  // ---------------------------------------------------------------
  task automatic creg_wr(input fpps_csel_t sel, input logic [31:0] d);
    @(negedge clk);
    creg_req <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
    @(negedge clk);
    creg_req <= '{wr: 1'b0, rd: 1'b0, sel: sel, wdata: ~d};
  endtask

  task automatic creg_rd(input fpps_csel_t sel, output logic [31:0] d);
    int n;
    @(negedge clk);
    creg_req <= '{wr: 1'b0, rd: 1'b1, sel: sel, wdata: rnd32()};
    @(negedge clk);
    creg_req.rd <= 1'b0;
    n = 0;
    while (creg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 4)
    begin
      failures++;
      tally_and_finish();
    end
    d = creg_rdata;
  endtask

  task automatic chk_regs();
    logic [31:0] r;
    creg_rd(sel_control, r);
    check(80'(r), 80'(e_ctrl), "control");
    creg_rd(sel_status, r);
    check(80'(r), 80'(e_stat), "status");
    creg_rd(sel_iaddr, r);
    check(80'(r), 80'(e_iaddr), "address");
    check(80'(cond_flags_out), 80'(e_stat[31:24]), "condition out");
  endtask

  task automatic chk_dregs();
    int n;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      dreg_rd <= 1'b1;
      dreg_rd_idx <= 3'(i);
      @(negedge clk);
      dreg_rd <= 1'b0;
      dreg_rd_idx <= ~3'(i);
      n = 0;
      while (dreg_rvalid !== 1'b1 && n < 4)
      begin
        @(negedge clk);
        n++;
      end
      if (n == 4)
      begin
        failures++;
        tally_and_finish();
      end
      check(dreg_rdata, e_dreg[i], "data register");
    end
  endtask

  task automatic do_op(input fpps_op_t k, input fpps_fmt_t f, input logic [79:0] v, input logic qv);
    logic [31:0] a;
    logic [7:0] x;
    logic [79:0] w;
    a = rnd32();
    x = a[23:16];
    w = (f == fmt_single) ? widen_single(v[31:0]) : (f == fmt_double) ? widen_double(v[63:0]) : v;
    u_iu.run_op(k, a, a[10:8], f, v, x, qv, a[7:0]);
    if (k != op_move_multiple)
    begin
      e_iaddr = a;
      e_stat[15:8] = x;
      if (qv)
        e_stat[23:16] = a[7:0];
    end
    if (k == op_arith || k == op_move_in)
      e_stat[31:24] = exp_cc(w);
    if (k == op_arith)
      e_stat[7:0] = exp_accr(e_stat[7:0], x);
    if (k != op_move_out)
      e_dreg[a[10:8]] = w;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [31:0] r2;
    logic [79:0] v;
    fpps_op_t k;
    logic [79:0] corner [4];
    corner = '{80'h0, 80'h7fff_8000_0000_0000_0000, QNAN_POS, 80'h8000_0000_0000_0000_0000};
    rstn = 1'b0;
    null_restore = 1'b0;
    creg_req = '0;
    dreg_rd = 1'b0;
    dreg_rd_idx = 3'h0;
    seed = 16'h3b2f;
    e_ctrl = 32'h0;
    e_stat = 32'h0;
    e_iaddr = 32'h0;
    for (int i = 0; i < 8; i++)
      e_dreg[i] = QNAN_POS;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk_regs();
    chk_dregs();
    for (int i = 0; i < 16; i++)
    begin
      d = rnd32();
      d[7:4] = 4'(i);
      creg_wr(sel_control, d);
      e_ctrl = d & 32'h0000_fff0;
      creg_wr(sel_none, rnd32());
      chk_regs();
      check(80'(trap_enable), 80'(d[15:8]), "trap enables");
      check(80'(round_mode), 80'(d[5:4]), "rounding mode");
      check(80'(round_rounding_precision_field), 80'(d[7:6]), "rounding precision");
      if (d[7:6] != 2'b11)
        check(80'(mant_round_bits), (d[7:6] == 2'b01) ? 80'd24 : 80'd64, "boundary");
    end
    for (int i = 0; i < 24; i++)
    begin
      // corners go through arithmetic so their condition flags are seen
      k = (i < 4) ? op_arith : fpps_op_t'(i % 4);
      d = rnd32();
      if (d[30:23] == 8'h00 || d[30:23] == 8'hff)
        d[30:23] = 8'h40;
      r2 = rnd32();
      v = (i < 4) ? corner[i] : {r2[15:0], rnd32(), rnd32()};
      if (k == op_move_in && i[2])
      begin
        v = {16'h0000, r2, d};
        if (v[62:52] == 11'h000 || v[62:52] == 11'h7ff)
          v[62:52] = 11'h400;
        do_op(k, fmt_double, v, i[3]);
      end
      else if (k == op_move_in)
        do_op(k, fmt_single, {48'h0, d}, i[3]);
      else
        do_op(k, fmt_extended, v, i[2]);
      chk_regs();
      if (i % 6 == 5)
      begin
        e_stat = rnd32();
        creg_wr(sel_status, e_stat);
        e_iaddr = rnd32();
        creg_wr(sel_iaddr, e_iaddr);
        chk_regs();
        check(80'(trap_enable), 80'(e_ctrl[15:8]), "enables kept");
      end
    end
    chk_dregs();
    @(negedge clk);
    null_restore <= 1'b1;
    @(negedge clk);
    null_restore <= 1'b0;
    e_ctrl = 32'h0;
    e_stat = 32'h0;
    e_iaddr = 32'h0;
    for (int i = 0; i < 8; i++)
      e_dreg[i] = QNAN_POS;
    chk_regs();
    chk_dregs();
    tally_and_finish();
  end
endmodule
